// file: core/srpcr_params.svh
// register offsets, field positions and reset values of the receiver phy configuration bank
`ifndef SRPCR_PARAMS_SVH
`define SRPCR_PARAMS_SVH

`define SRPCR_ADDR_W 12
`define SRPCR_DATA_W 8

`define SRPCR_OFS_MASTER_PD 12'h200
`define SRPCR_OFS_LANE_PD 12'h201
`define SRPCR_OFS_MISC_PD 12'h203
`define SRPCR_OFS_RECOVERY_RESET 12'h206
`define SRPCR_OFS_OPER_MODE 12'h230
`define SRPCR_OFS_EQ_LANES_0_1 12'h250

`define SRPCR_RST_MASTER_PD 1'h1
`define SRPCR_RST_LANE_PD 8'h00
`define SRPCR_RST_MISC_PD 2'h0
`define SRPCR_RST_RECOVERY_RESET 1'h1
`define SRPCR_RST_OPER_MODE 8'h60
`define SRPCR_RST_EQ_LANES_0_1 8'h88

`define SRPCR_BIT_MASTER_PD 0
`define SRPCR_BIT_SYNC_PD 1
`define SRPCR_BIT_RECOVERY_RUN 0
`define SRPCR_BIT_HALF_RATE 5
`define SRPCR_POS_DIV_LO 1
`define SRPCR_POS_DIV_HI 2
`define SRPCR_POS_EQ0_LO 0
`define SRPCR_POS_EQ0_HI 3
`define SRPCR_POS_EQ1_LO 4
`define SRPCR_POS_EQ1_HI 7

`define SRPCR_EQ_CODE_MANUAL 4'h0

`endif

// file: core/srpcr_pkg.sv
// types shared by the receiver phy configuration bank
package srpcr_pkg;
  typedef logic [11:0] srpcr_addr_type;
  typedef logic [7:0] srpcr_byte_type;
  typedef logic [3:0] srpcr_eq_code_type;
  typedef enum logic {SRPCR_EQ_MANUAL, SRPCR_EQ_BOOST} srpcr_eq_mode_type;
endpackage : srpcr_pkg

// file: core/srpcr_eq_if.sv
// equalizer code and decoded setting for one lane
`timescale 1ns/1ns
interface srpcr_eq_if;
  import srpcr_pkg::*;
  srpcr_eq_code_type code;
  srpcr_eq_mode_type mode;
  srpcr_eq_code_type boost;
  modport ctrl (output code, input mode, input boost);
  modport dec (input code, output mode, output boost);
endinterface : srpcr_eq_if

// file: core/srpcr_eq_decode.sv
// per-lane equalizer code decode into manual mode or boost level
`timescale 1ns/1ns
`include "srpcr_params.svh"
module srpcr_eq_decode
  import srpcr_pkg::*;
(
  // clock and reset for checks
  input wire logic i_mclk,
  input wire logic i_reset,
  // code in, setting out
  srpcr_eq_if.dec eq
);

  always_comb begin
    if (eq.code == `SRPCR_EQ_CODE_MANUAL) begin
      eq.mode = SRPCR_EQ_MANUAL;
      eq.boost = `SRPCR_EQ_CODE_MANUAL;
    end else begin
      eq.mode = SRPCR_EQ_BOOST;
      eq.boost = eq.code;
    end
  end

  property p_boost_level;
    @(posedge i_mclk) disable iff (i_reset)
    (eq.code != 4'h0) |-> (eq.mode == SRPCR_EQ_BOOST) && (eq.boost == eq.code);
  endproperty
  a_boost_level: assert property (p_boost_level) else $error("boost level differs from code");

  property p_manual;
    @(posedge i_mclk) disable iff (i_reset)
    (eq.code == 4'h0) |-> (eq.mode == SRPCR_EQ_MANUAL);
  endproperty
  a_manual: assert property (p_manual) else $error("zero code not manual");

endmodule : srpcr_eq_decode

// file: core/srpcr_regs.sv
// receiver phy configuration register bank with lane control outputs
`timescale 1ns/1ns
`include "srpcr_params.svh"
module srpcr_regs
  import srpcr_pkg::*;
(
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_reset,
  // register access from the configuration port
  input wire logic [11:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_rd,
  output logic [7:0] o_reg_rdata,
  output logic o_reg_rvalid,
  // power controls
  output logic [7:0] o_lane_power_down,
  output logic o_bias_power_down,
  output logic o_sync_buffer_power_down,
  // recovery controls
  output logic o_recovery_reset_n,
  output logic o_half_rate_enable,
  output logic [1:0] o_division_rate,
  // equalizer settings
  output logic o_lane0_manual,
  output logic [3:0] o_lane0_boost,
  output logic o_lane1_manual,
  output logic [3:0] o_lane1_boost
);

  logic receiver_master_power_down;
  srpcr_byte_type lane_power_down_override;
  logic [1:0] misc_power_down;
  logic recovery_reset_n;
  srpcr_byte_type recovery_operating_mode;
  srpcr_byte_type equalizer_lanes_0_1;

  logic next_master;
  srpcr_byte_type next_lane;
  logic [1:0] next_misc;
  logic next_recovery;
  srpcr_byte_type next_mode;
  srpcr_byte_type next_eq;
  srpcr_byte_type next_rdata;
  logic next_rvalid;

  srpcr_eq_if eq0 ();
  srpcr_eq_if eq1 ();

  assign eq0.code = equalizer_lanes_0_1[`SRPCR_POS_EQ0_HI:`SRPCR_POS_EQ0_LO];
  assign eq1.code = equalizer_lanes_0_1[`SRPCR_POS_EQ1_HI:`SRPCR_POS_EQ1_LO];

  srpcr_eq_decode u_eq0 (
    .i_mclk(i_mclk),
    .i_reset(i_reset),
    .eq(eq0.dec)
  );

  srpcr_eq_decode u_eq1 (
    .i_mclk(i_mclk),
    .i_reset(i_reset),
    .eq(eq1.dec)
  );

  // register writes
  always_comb begin
    next_master = receiver_master_power_down;
    next_lane = lane_power_down_override;
    next_misc = misc_power_down;
    next_recovery = recovery_reset_n;
    next_mode = recovery_operating_mode;
    next_eq = equalizer_lanes_0_1;
    if (i_reg_wr) begin
      case (i_reg_addr)
        `SRPCR_OFS_MASTER_PD: begin
          next_master = i_reg_wdata[`SRPCR_BIT_MASTER_PD];
        end
        `SRPCR_OFS_LANE_PD: begin
          next_lane = i_reg_wdata;
        end
        `SRPCR_OFS_MISC_PD: begin
          next_misc = i_reg_wdata[1:0];
        end
        `SRPCR_OFS_RECOVERY_RESET: begin
          next_recovery = i_reg_wdata[`SRPCR_BIT_RECOVERY_RUN];
        end
        `SRPCR_OFS_OPER_MODE: begin
          next_mode = i_reg_wdata;
        end
        `SRPCR_OFS_EQ_LANES_0_1: begin
          next_eq = i_reg_wdata;
        end
        default: begin
          next_master = receiver_master_power_down;
        end
      endcase
    end
  end

  // register reads, unmapped and reserved bits read zero
  always_comb begin
    next_rdata = 8'h00;
    next_rvalid = i_reg_rd;
    if (i_reg_rd) begin
      case (i_reg_addr)
        `SRPCR_OFS_MASTER_PD: next_rdata = {7'h00, receiver_master_power_down};
        `SRPCR_OFS_LANE_PD: next_rdata = lane_power_down_override;
        `SRPCR_OFS_MISC_PD: next_rdata = {6'h00, misc_power_down};
        `SRPCR_OFS_RECOVERY_RESET: next_rdata = {7'h00, recovery_reset_n};
        `SRPCR_OFS_OPER_MODE: next_rdata = recovery_operating_mode;
        `SRPCR_OFS_EQ_LANES_0_1: next_rdata = equalizer_lanes_0_1;
        default: next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      receiver_master_power_down <= `SRPCR_RST_MASTER_PD;
      lane_power_down_override <= `SRPCR_RST_LANE_PD;
      misc_power_down <= `SRPCR_RST_MISC_PD;
      recovery_reset_n <= `SRPCR_RST_RECOVERY_RESET;
      recovery_operating_mode <= `SRPCR_RST_OPER_MODE;
      equalizer_lanes_0_1 <= `SRPCR_RST_EQ_LANES_0_1;
      o_reg_rdata <= 8'h00;
      o_reg_rvalid <= 1'b0;
    end else begin
      receiver_master_power_down <= next_master;
      lane_power_down_override <= next_lane;
      misc_power_down <= next_misc;
      recovery_reset_n <= next_recovery;
      recovery_operating_mode <= next_mode;
      equalizer_lanes_0_1 <= next_eq;
      o_reg_rdata <= next_rdata;
      o_reg_rvalid <= next_rvalid;
    end
  end

  // lane controls registered from next state, so they track the registers
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      o_lane_power_down <= 8'hFF;
      o_bias_power_down <= 1'b1;
      o_sync_buffer_power_down <= 1'b0;
      o_recovery_reset_n <= 1'b1;
      o_half_rate_enable <= 1'b1;
      o_division_rate <= 2'h0;
    end else begin
      o_lane_power_down <= next_lane | {8{next_master}};
      o_bias_power_down <= next_master;
      o_sync_buffer_power_down <= next_misc[`SRPCR_BIT_SYNC_PD];
      o_recovery_reset_n <= next_recovery;
      o_half_rate_enable <= next_mode[`SRPCR_BIT_HALF_RATE];
      o_division_rate <= next_mode[`SRPCR_POS_DIV_HI:`SRPCR_POS_DIV_LO];
    end
  end

  // decoded equalizer settings, one cycle behind the register
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      o_lane0_manual <= 1'b0;
      o_lane0_boost <= 4'h8;
      o_lane1_manual <= 1'b0;
      o_lane1_boost <= 4'h8;
    end else begin
      o_lane0_manual <= (eq0.mode == SRPCR_EQ_MANUAL);
      o_lane0_boost <= eq0.boost;
      o_lane1_manual <= (eq1.mode == SRPCR_EQ_MANUAL);
      o_lane1_boost <= eq1.boost;
    end
  end

  property p_lane_write;
    @(posedge i_mclk) disable iff (i_reset)
    (i_reg_wr && i_reg_addr == 12'h201 && !receiver_master_power_down)
      |=> o_lane_power_down == $past(i_reg_wdata);
  endproperty
  a_lane_write: assert property (p_lane_write) else $error("lane power down not per bit");

  property p_lane_reset;
    @(posedge i_mclk)
    $fell(i_reset) |-> (lane_power_down_override == 8'h00) && receiver_master_power_down;
  endproperty
  a_lane_reset: assert property (p_lane_reset) else $error("power down reset values wrong");

  property p_master_all;
    @(posedge i_mclk) disable iff (i_reset)
    (i_reg_wr && i_reg_addr == 12'h200 && i_reg_wdata[0])
      |=> (o_lane_power_down == 8'hFF) && o_bias_power_down;
  endproperty
  a_master_all: assert property (p_master_all) else $error("master did not power down all");

  property p_sync_pd;
    @(posedge i_mclk) disable iff (i_reset)
    (i_reg_wr && i_reg_addr == 12'h203) |=> o_sync_buffer_power_down == $past(i_reg_wdata[1]);
  endproperty
  a_sync_pd: assert property (p_sync_pd) else $error("sync buffer power down wrong");

  property p_recovery;
    @(posedge i_mclk) disable iff (i_reset)
    (i_reg_wr && i_reg_addr == 12'h206 && !i_reg_wdata[0]) ##1 !i_reg_wr [*2] |=> !o_recovery_reset_n;
  endproperty
  a_recovery: assert property (p_recovery) else $error("recovery logic not held in reset");

  property p_mode_fields;
    @(posedge i_mclk) disable iff (i_reset)
    (i_reg_wr && i_reg_addr == 12'h230)
      |=> (o_half_rate_enable == $past(i_reg_wdata[5])) && (o_division_rate == $past(i_reg_wdata[2:1]));
  endproperty
  a_mode_fields: assert property (p_mode_fields) else $error("mode fields not applied");

  property p_eq_reset;
    @(posedge i_mclk)
    $fell(i_reset) |-> (equalizer_lanes_0_1 == 8'h88) ##1 (o_lane1_boost == 4'h8) && !o_lane0_manual;
  endproperty
  a_eq_reset: assert property (p_eq_reset) else $error("equalizer reset wrong");

  property p_eq_boost;
    @(posedge i_mclk) disable iff (i_reset)
    (i_reg_wr && i_reg_addr == 12'h250 && i_reg_wdata[7:4] != 4'h0)
      |=> ##1 (o_lane1_boost == $past(i_reg_wdata[7:4], 2)) && !o_lane1_manual;
  endproperty
  a_eq_boost: assert property (p_eq_boost) else $error("lane 1 boost wrong");

  property p_read_eq;
    @(posedge i_mclk) disable iff (i_reset)
    (i_reg_rd && i_reg_addr == 12'h250) |=> o_reg_rvalid && (o_reg_rdata == $past(equalizer_lanes_0_1));
  endproperty
  a_read_eq: assert property (p_read_eq) else $error("equalizer readback wrong");

endmodule : srpcr_regs

// file: bench/srpcr_host.sv
// host model driving the register access port
`timescale 1ns/1ns
module srpcr_host (
  // clock
  input wire logic i_mclk,
  // register port
  output logic [11:0] o_reg_addr,
  output logic o_reg_wr,
  output logic [7:0] o_reg_wdata,
  output logic o_reg_rd,
  input wire logic [7:0] i_reg_rdata,
  input wire logic i_reg_rvalid
);
  initial begin
    o_reg_addr = 12'hFFF;
    o_reg_wr = 1'b0;
    o_reg_wdata = 8'h00;
    o_reg_rd = 1'b0;
  end
  task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
    @(negedge i_mclk);
    o_reg_addr = a;
    o_reg_wdata = d;
    o_reg_wr = 1'b1;
    @(negedge i_mclk);
    o_reg_wr = 1'b0;
    o_reg_addr = ~a;
    o_reg_wdata = ~d;
  endtask : wr_reg
  task automatic rd_reg(input logic [11:0] a, output logic [7:0] d, output logic v);
    @(negedge i_mclk);
    o_reg_addr = a;
    o_reg_rd = 1'b1;
    @(negedge i_mclk);
    o_reg_rd = 1'b0;
    o_reg_addr = ~a;
    d = i_reg_rdata;
    v = i_reg_rvalid;
  endtask : rd_reg
  // operating mode byte for a lane rate in Mbps
  function automatic logic [7:0] mode_for(input int mbps);
    logic h;
    logic [1:0] dv;
    h = (mbps > 6000);
    dv = (mbps > 3000) ? 2'h0 : (mbps > 1500) ? 2'h1 : 2'h2;
    return {2'h1, h, 2'h0, dv, 1'h0};
  endfunction : mode_for
endmodule : srpcr_host

// file: bench/testbench.sv
// self-checking bench for the receiver phy configuration bank
`timescale 1ns/1ns
module testbench;
  import srpcr_pkg::*;
  logic i_mclk, i_reset, wr, rd, rvalid, bias_pd, sync_pd, rec_n, half, m0, m1;
  logic [11:0] addr;
  logic [7:0] wdata, rdata, lane_pd;
  logic [1:0] div;
  logic [3:0] b0, b1, cc, ce;
  int n_fail = 0;
  int compares = 0;
  int rates[5] = '{8000, 6001, 6000, 2000, 1000};

  initial begin
    i_mclk = 1'b0;
    forever #50 i_mclk = ~i_mclk;
  end

  srpcr_regs dut (.i_mclk(i_mclk), .i_reset(i_reset), .i_reg_addr(addr), .i_reg_wr(wr),
    .i_reg_wdata(wdata), .i_reg_rd(rd), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid),
    .o_lane_power_down(lane_pd), .o_bias_power_down(bias_pd), .o_sync_buffer_power_down(sync_pd),
    .o_recovery_reset_n(rec_n), .o_half_rate_enable(half), .o_division_rate(div),
    .o_lane0_manual(m0), .o_lane0_boost(b0), .o_lane1_manual(m1), .o_lane1_boost(b1));

  srpcr_host host (.i_mclk(i_mclk), .o_reg_addr(addr), .o_reg_wr(wr), .o_reg_wdata(wdata),
    .o_reg_rd(rd), .i_reg_rdata(rdata), .i_reg_rvalid(rvalid));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic rd_check(input logic [11:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic v;
    host.rd_reg(a, d, v);
    check({7'h00, v}, 8'h01);
    check(d, exp);
  endtask : rd_check

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : give_verdict

  initial begin
    #(3000 * 100);
    n_fail++;
    give_verdict();
  end

  initial begin
    i_reset = 1'b1;
    repeat (20) @(negedge i_mclk);
    i_reset = 1'b0;
    rd_check(12'h200, 8'h01);
    rd_check(12'h201, 8'h00);
    rd_check(12'h203, 8'h00);
    rd_check(12'h206, 8'h01);
    rd_check(12'h230, 8'h60);
    rd_check(12'h250, 8'h88);
    rd_check(12'h202, 8'h00);
    check({lane_pd[7:1], bias_pd}, 8'hFF);
    check({4'h0, sync_pd, rec_n, half, m0}, 8'h06);
    check({b1, b0}, 8'h88);
    $display("reset test done");
    host.wr_reg(12'h201, 8'h0A);
    check(lane_pd, 8'hFF);
    host.wr_reg(12'h200, 8'h00);
    check({lane_pd[6:0], bias_pd}, 8'h14);
    for (int n = 0; n < 8; n++) begin
      host.wr_reg(12'h201, 8'h01 << n);
      check(lane_pd, 8'h01 << n);
    end
    rd_check(12'h201, 8'h80);
    host.wr_reg(12'h200, 8'h01);
    rd_check(12'h200, 8'h01);
    check({lane_pd[6:0], bias_pd}, 8'hFF);
    $display("power test done");
    host.wr_reg(12'h203, 8'h02);
    rd_check(12'h203, 8'h02);
    check({7'h00, sync_pd}, 8'h01);
    host.wr_reg(12'h203, 8'h00);
    check({7'h00, sync_pd}, 8'h00);
    host.wr_reg(12'h206, 8'h00);
    check({7'h00, rec_n}, 8'h00);
    rd_check(12'h206, 8'h00);
    host.wr_reg(12'h206, 8'h01);
    check({7'h00, rec_n}, 8'h01);
    $display("misc test done");
    foreach (rates[i]) begin
      host.wr_reg(12'h230, host.mode_for(rates[i]));
      cc = (rates[i] > 3000) ? 4'h0 : (rates[i] > 1500) ? 4'h1 : 4'h2;
      check({5'h00, half, div}, {5'h00, rates[i] > 6000, cc[1:0]});
      rd_check(12'h230, {3'h2 | (rates[i] > 6000), 2'h0, cc[1:0], 1'h0});
    end
    $display("mode test done");
    for (int c = 0; c < 16; c++) begin
      cc = c[3:0];
      ce = ~cc;
      host.wr_reg(12'h250, {cc, ce});
      @(negedge i_mclk);
      check({3'h0, m1, b1}, {3'h0, cc == 4'h0, cc});
      check({3'h0, m0, b0}, {3'h0, ce == 4'h0, ce});
    end
    rd_check(12'h250, 8'hF0);
    $display("equalizer test done");
    i_reset = 1'b1;
    repeat (2) @(negedge i_mclk);
    i_reset = 1'b0;
    check({3'h0, m0, b0}, 8'h08);
    rd_check(12'h250, 8'h88);
    rd_check(12'h201, 8'h00);
    $display("second reset test done");
    give_verdict();
  end
endmodule : testbench
